// *** rtl/tpg_consts.svh ***
// Contract
// - High-side command is active low; low requests high-side gate on.
// - Low-side command is active high; high requests low-side gate on.
// - Gates may turn on only while both enables are high, ANDed.
// - Either enable low forces all six gates off; other logic keeps running.
// - Enables act without waiting for any clock edge.
// - After re-enable, high side stays off until its low side was pulsed.
// - Reset low means low power with every output disabled.
// - Reset low clears internal logic within 77 ns, without a clock; registers here clear on the next clock edge.
// - Interlock and dead time keep both sides off together; each overridable.
// - Phase status low when phase source below half supply, else high.
// - Overcurrent comparator result goes out on its own status output.
// - Overcurrent status high means overcurrent, low otherwise.
// - Undriven high commands read inactive high, low commands inactive low.
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
`define TPG_PHASES 3
`define TPG_DT_W 8
`define TPG_RESET_MAX_NS 77
`define TPG_CLK_NS 25
// Reset reach in cycles, rounded down, at least one
`define TPG_RESET_CYC ((`TPG_RESET_MAX_NS / `TPG_CLK_NS) < 1 ? 1 : (`TPG_RESET_MAX_NS / `TPG_CLK_NS))
`define TPG_OVR_XCOND 0
`define TPG_OVR_DEADT 1
`endif

// *** rtl/tpg_pkg.sv ***
`include "tpg_consts.svh"
package tpg_pkg;
    typedef enum logic [1:0] {
        TPG_OFF = 2'b00,
        TPG_DEAD = 2'b01,
        TPG_LOW = 2'b11,
        TPG_HIGH = 2'b10
    } tpg_phase_state_t;
endpackage

// *** rtl/tpg_phase.sv ***
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tpg_phase
    import tpg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Gating
    input wire logic i_gate_ok,
    input wire logic i_high_req,
    input wire logic i_low_req,
    // Configuration
    input wire logic [`TPG_DT_W-1:0] i_dead_cycles,
    input wire logic i_ovr_xcond,
    input wire logic i_ovr_dead,
    // Gate enables before the asynchronous mask
    output logic o_high_on,
    output logic o_low_on
);
    tpg_phase_state_t state, next_state;
    logic [`TPG_DT_W-1:0] dt_cnt, next_dt_cnt;
    logic primed, next_primed;
    logic want_high, want_low;

    // With interlock overridden both sides may be requested together; high still needs priming
    always_comb begin
        want_high = i_high_req && primed;
        want_low = i_low_req;
        if (!i_ovr_xcond && want_high && want_low) begin
            want_high = 1'b0;
            want_low = 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        next_dt_cnt = dt_cnt;
        next_primed = primed;
        if (state == TPG_LOW) begin
            next_primed = 1'b1;
        end
        case (state)
            TPG_OFF: begin
                if (want_low) begin
                    next_state = TPG_LOW;
                end else if (want_high) begin
                    next_state = TPG_HIGH;
                end
            end
            TPG_DEAD: begin
                if (dt_cnt != '0) begin
                    next_dt_cnt = dt_cnt - 1'b1;
                end else begin
                    next_state = TPG_OFF;
                end
            end
            TPG_LOW: begin
                if (!want_low) begin
                    next_state = TPG_DEAD;
                    next_dt_cnt = i_dead_cycles;
                end
            end
            TPG_HIGH: begin
                if (!want_high) begin
                    next_state = TPG_DEAD;
                    next_dt_cnt = i_dead_cycles;
                end
            end
            default: begin
                next_state = TPG_OFF;
            end
        endcase
        if (!i_gate_ok) begin
            next_state = TPG_OFF;
            next_primed = 1'b0;
            next_dt_cnt = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= TPG_OFF;
            dt_cnt <= '0;
            primed <= 1'b0;
        end else begin
            state <= next_state;
            dt_cnt <= next_dt_cnt;
            primed <= next_primed;
        end
    end

    // Dead time override bypasses the sequencer; interlock still applies
    always_comb begin
        if (i_ovr_dead) begin
            o_high_on = want_high;
            o_low_on = want_low;
        end else begin
            o_high_on = (state == TPG_HIGH) && want_high;
            o_low_on = (state == TPG_LOW) && want_low;
        end
    end
endmodule

// *** rtl/tpg_gate_logic.sv ***
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tpg_gate_logic
    import tpg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_reset_n,
    // Enables
    input wire logic i_drive_enable_first,
    input wire logic i_drive_enable_second,
    // Phase commands
    input wire logic [`TPG_PHASES-1:0] i_phase_high_cmd_n,
    input wire logic [`TPG_PHASES-1:0] i_phase_low_cmd,
    input wire logic [`TPG_PHASES-1:0] i_cmd_driven,
    // Configuration
    input wire logic [`TPG_DT_W-1:0] i_dead_cycles,
    input wire logic [1:0] i_override,
    // Comparators
    input wire logic [`TPG_PHASES-1:0] i_phase_src_above_half,
    input wire logic i_overcurrent_cmp,
    // Gate drives
    output logic [`TPG_PHASES-1:0] o_high_side_drive,
    output logic [`TPG_PHASES-1:0] o_low_side_drive,
    // Status
    output logic [`TPG_PHASES-1:0] o_phase_level_status,
    output logic o_overcurrent_flag,
    output logic o_low_power
);
    logic gate_ok;
    logic core_rst;
    logic [`TPG_PHASES-1:0] high_req, low_req, high_on, low_on;
    logic [`TPG_PHASES-1:0] next_phase_status, phase_status;
    logic next_oc, oc;

    // Pin reset reaches logic next clock (25 ns) and gates combinationally
    assign core_rst = i_srst || !i_reset_n;
    assign gate_ok = i_drive_enable_first && i_drive_enable_second;
    assign o_low_power = !i_reset_n;

    genvar p;
    generate
        for (p = 0; p < `TPG_PHASES; p = p + 1) begin : g_phase
            // Floating pins default to the inactive level
            assign high_req[p] = i_cmd_driven[p] && !i_phase_high_cmd_n[p];
            assign low_req[p] = i_cmd_driven[p] && i_phase_low_cmd[p];
            tpg_phase u_phase (
                .i_clk_sys(i_clk_sys),
                .i_srst(core_rst),
                .i_gate_ok(gate_ok),
                .i_high_req(high_req[p]),
                .i_low_req(low_req[p]),
                .i_dead_cycles(i_dead_cycles),
                .i_ovr_xcond(i_override[`TPG_OVR_XCOND]),
                .i_ovr_dead(i_override[`TPG_OVR_DEADT]),
                .o_high_on(high_on[p]),
                .o_low_on(low_on[p])
            );
        end
    endgenerate

    // Final mask is combinational so enables and reset need no clock edge
    always_comb begin
        if (gate_ok && i_reset_n && !i_srst) begin
            o_high_side_drive = high_on;
            o_low_side_drive = low_on;
        end else begin
            o_high_side_drive = '0;
            o_low_side_drive = '0;
        end
    end

    always_comb begin
        next_phase_status = i_phase_src_above_half;
        next_oc = i_overcurrent_cmp;
    end

    always_ff @(posedge i_clk_sys) begin
        if (core_rst) begin
            phase_status <= '0;
            oc <= 1'b0;
        end else begin
            phase_status <= next_phase_status;
            oc <= next_oc;
        end
    end

    // Outputs cleared on the next clock edge in low power, then held low
    assign o_phase_level_status = phase_status;
    assign o_overcurrent_flag = oc;
endmodule

// *** verif/tpg_monitor.sv ***
`timescale 1ns/10ps
module tpg_monitor (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_reset_n,
    // Stimulus
    input wire logic i_drive_enable_first,
    input wire logic i_drive_enable_second,
    input wire logic [2:0] i_phase_high_cmd_n,
    input wire logic [2:0] i_phase_low_cmd,
    input wire logic [1:0] i_override,
    input wire logic [2:0] i_phase_src_above_half,
    input wire logic i_overcurrent_cmp,
    // Responses
    input wire logic [2:0] o_high_side_drive,
    input wire logic [2:0] o_low_side_drive,
    input wire logic [2:0] o_phase_level_status,
    input wire logic o_overcurrent_flag,
    input wire logic o_low_power
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire logic en = i_drive_enable_first & i_drive_enable_second;
    wire logic [2:0] hs = o_high_side_drive;
    wire logic [2:0] ls = o_low_side_drive;
    // Status regs are only valid one edge after both resets are gone
    logic calm;
    always_ff @(posedge i_clk_sys) calm <= i_reset_n & ~i_srst;
    gate_off_a: assert property (!en |-> (hs | ls) == 3'h0)
        else $error("drive on while disabled");
    rst_mask_a: assert property (!i_reset_n |-> (hs | ls) == 3'h0 && o_low_power)
        else $error("drive on in reset");
    x_cond_a: assert property (!i_override[0] |-> (hs & ls) == 3'h0)
        else $error("both sides on");
    low_req_a: assert property ($rose(ls[0]) |-> $past(i_phase_low_cmd[0]))
        else $error("low on without request");
    high_req_a: assert property ($rose(hs[0]) |-> !$past(i_phase_high_cmd_n[0]))
        else $error("high on without request");
    prime_a: assert property ($rose(en) |-> hs == 3'h0 [*2])
        else $error("high on before low pulse");
    oc_flag_a: assert property (calm && i_reset_n |->
        o_overcurrent_flag == $past(i_overcurrent_cmp))
        else $error("overcurrent flag wrong");
    phase_stat_a: assert property (calm && i_reset_n |->
        o_phase_level_status == $past(i_phase_src_above_half))
        else $error("phase status wrong");
endmodule
bind tpg_gate_logic tpg_monitor tpg_monitor_i (.*);

// *** verif/tpg_mcu.sv ***
`timescale 1ns/10ps
module tpg_mcu (
    // Clock
    input wire logic i_clk_sys,
    // Pins toward the gate logic
    output logic [2:0] o_high_cmd_n,
    output logic [2:0] o_low_cmd,
    output logic [1:0] o_enable,
    output logic o_reset_n
);
    initial begin
        o_high_cmd_n = 3'h7;
        o_low_cmd = 3'h0;
        o_enable = 2'h0;
        o_reset_n = 1'h1;
    end
    task automatic put(input logic [2:0] hn, input logic [2:0] lo);
        @(posedge i_clk_sys);
        #1;
        o_high_cmd_n = hn;
        o_low_cmd = lo;
    endtask
    // Charge bootstraps first, wait out dead time, then ask high
    task automatic prime_high();
        put(3'h7, 3'h7);
        put(3'h7, 3'h0);
        repeat (6) @(posedge i_clk_sys);
        put(3'h0, 3'h0);
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic clk, srst, oc;
    logic [2:0] src;
    logic [2:0] drv;
    logic [1:0] ovr;
    wire logic [2:0] hn, lo, hs, ls, stat;
    wire logic [1:0] en;
    wire logic rst_n, flag, lp;
    int bad_count = 0;
    int n_compared = 0;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    tpg_mcu tpg_mcu_i (.i_clk_sys(clk), .o_high_cmd_n(hn), .o_low_cmd(lo), .o_enable(en),
        .o_reset_n(rst_n));
    tpg_gate_logic tpg_gate_logic_i (.i_clk_sys(clk), .i_srst(srst), .i_reset_n(rst_n),
        .i_drive_enable_first(en[0]), .i_drive_enable_second(en[1]), .i_phase_high_cmd_n(hn),
        .i_phase_low_cmd(lo), .i_cmd_driven(drv), .i_dead_cycles(8'h02), .i_override(ovr),
        .i_phase_src_above_half(src), .i_overcurrent_cmp(oc), .o_high_side_drive(hs),
        .o_low_side_drive(ls), .o_phase_level_status(stat), .o_overcurrent_flag(flag),
        .o_low_power(lp));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_prime();
        tpg_mcu_i.o_enable = 2'h3;
        tpg_mcu_i.put(3'h0, 3'h0);
        tick(3);
        chk("high unprimed", hs, 8'h00);
        tpg_mcu_i.prime_high();
        tick(1);
        chk("high primed", hs, 8'h07);
    endtask
    task automatic t_enable();
        for (int i = 1; i < 3; i++) begin
            tpg_mcu_i.o_enable = i[1:0];
            #1;
            chk("async off", {ls, hs}, 8'h00);
            tick(2);
            tpg_mcu_i.o_enable = 2'h3;
            tick(3);
            chk("high reenabled", hs, 8'h00);
            tpg_mcu_i.prime_high();
            tick(1);
            chk("high reprimed", hs, 8'h07);
        end
    endtask
    task automatic t_xcond();
        tpg_mcu_i.put(3'h0, 3'h7);
        tick(2);
        chk("both asked", {ls, hs}, 8'h00);
        tpg_mcu_i.put(3'h7, 3'h7);
        // Dead time of two cycles still runs out before low may start
        tick(2);
        chk("low on", ls, 8'h07);
    endtask
    task automatic t_status();
        for (int i = 0; i < 2; i++) begin
            src = i ? 3'h5 : 3'h2;
            oc = i[0];
            tick(1);
            chk("phase status", stat, i ? 8'h05 : 8'h02);
            chk("overcurrent", flag, i ? 8'h01 : 8'h00);
        end
    endtask
    task automatic t_float();
        drv = 3'h6;
        #1;
        chk("float low", ls, 8'h06);
        tpg_mcu_i.put(3'h0, 3'h0);
        tick(5);
        chk("float high", hs, 8'h06);
        drv = 3'h7;
    endtask
    task automatic t_override();
        ovr = 2'h2;
        tpg_mcu_i.put(3'h0, 3'h7);
        #1;
        chk("ovr both off", {ls, hs}, 8'h00);
        tick(1);
        ovr = 2'h3;
        #1;
        chk("ovr both on", {ls, hs}, 8'h3f);
        tick(1);
        ovr = 2'h0;
        #1;
        chk("ovr restored", {ls, hs}, 8'h00);
    endtask
    task automatic t_reset();
        tpg_mcu_i.o_reset_n = 1'b0;
        #1;
        chk("reset drives", {lp, ls, hs}, 8'h40);
        tick(1);
        chk("reset logic", {flag, stat}, 8'h00);
        tpg_mcu_i.put(3'h0, 3'h0);
        tpg_mcu_i.o_reset_n = 1'b1;
        tick(3);
        chk("high after reset", hs, 8'h00);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        src = 3'h0;
        oc = 1'b0;
        drv = 3'h7;
        ovr = 2'h0;
        tick(12);
        srst = 1'b0;
        tick(1);
        t_prime();
        t_enable();
        t_xcond();
        t_status();
        t_float();
        t_override();
        t_reset();
        finish_test();
    end
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
